// ### rtl/sensor_regs_pkg.sv
`default_nettype none
package sensor_regs_pkg;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [6:0] ADDR_REVISION = 7'h00;
    localparam logic [6:0] ADDR_UPPER = 7'h01;
    localparam logic [6:0] ADDR_LOWER = 7'h02;
    localparam logic [6:0] ADDR_WATCHDOG = 7'h03;
    localparam logic [6:0] ADDR_CONV_CFG = 7'h04;
    localparam logic [6:0] ADDR_RSVD_05 = 7'h05;
    localparam logic [6:0] ADDR_RSVD_06 = 7'h06;
    localparam logic [6:0] ADDR_THR_HIGH = 7'h07;
    localparam logic [6:0] ADDR_RSVD_08 = 7'h08;
    localparam logic [6:0] ADDR_THR_LOW = 7'h09;
    localparam logic [6:0] ADDR_INT_CFG = 7'h0A;
    localparam logic [6:0] ADDR_POWER = 7'h0B;
    localparam logic [6:0] ADDR_STATUS = 7'h20;
    localparam logic [6:0] ADDR_RSVD_21 = 7'h21;
    localparam logic [6:0] ADDR_PROX = 7'h22;
    localparam logic [6:0] ADDR_FREQ_LOW = 7'h23;
    localparam logic [6:0] ADDR_FREQ_MID = 7'h24;
    localparam logic [6:0] ADDR_FREQ_HIGH = 7'h25;
    localparam logic [6:0] ADDR_LOCK_FIRST = 7'h01;
    localparam logic [6:0] ADDR_LOCK_LAST = 7'h05;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_UPPER = 8'h0E;
    localparam logic [7:0] RST_LOWER = 8'h14;
    localparam logic [7:0] RST_WATCHDOG = 8'h45;
    localparam logic [7:0] RST_CONV_CFG = 8'h1B;
    localparam logic [7:0] VAL_RSVD_05 = 8'h01;
    localparam logic [7:0] RST_RSVD_06 = 8'hFF;
    localparam logic [7:0] RST_THR_HIGH = 8'hFF;
    localparam logic [7:0] RST_RSVD_08 = 8'h00;
    localparam logic [7:0] RST_THR_LOW = 8'h00;
    localparam logic [7:0] RST_INT_CFG = 8'h00;
    localparam logic RST_ACTIVE = 1'b0;

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int DIR_BIT = 7;
    localparam logic DIR_READ = 1'b1;
    localparam int ACTIVE_BIT = 0;
    localparam int RANGE_MSB = 4;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic {
        PH_CMD = 1'b0,
        PH_DATA = 1'b1
    } phase_e;

    typedef struct packed {
        logic [7:0] resist_range_upper;
        logic [7:0] resist_range_lower;
        logic [7:0] min_sensor_freq_watchdog;
        logic [7:0] converter_config;
        logic [7:0] prox_threshold_high;
        logic [7:0] prox_threshold_low;
        logic [7:0] interrupt_pin_config;
        logic active_mode_bit;
    } config_s;

    typedef struct packed {
        logic osc_dead;
        logic data_ready_n;
        logic wakeup_n;
        logic comparator;
        logic [7:0] proximity;
        logic [23:0] freq_count;
    } result_s;

    // range index 0..31 for both limit registers (upper 0x00.., lower 0x20..)
    function automatic logic [4:0] range_index(input logic [7:0] code);
        range_index = code[RANGE_MSB:0];
    endfunction

endpackage
`default_nettype wire

// ### rtl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    // a zero-width synchroniser cannot be built
    if (WIDTH < 1) begin : g_width_check
        $error("pin_sync needs a width of at least one");
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;
endmodule // pin_sync
`default_nettype wire

// ### rtl/inductive_sensor_register_bank.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - registers 0x01-0x05 locked while active
// - upper limit codes 0x00-0x1F, 32 ranges
// - lower limit codes 0x20-0x3F, same ranges
// - upper limit at 0x01, RW, reset 0x0E
// - lower limit at 0x02, RW, reset 0x14
// - read-only revision byte at address zero
// - command byte: direction bit, 7-bit address
// - address auto-increments per further data byte
// - commit on 16th rise and every 8th rise after it; early deselect aborts
// - power bit 0 selects standby or active
module inductive_sensor_register_bank #(
    parameter logic [7:0] REVISION_ID = 8'h5A  // arbitrary value
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // serial port pins
    input wire logic sclk_in,
    input wire logic chip_select_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    // conversion side
    input wire sensor_regs_pkg::result_s result_in,
    output sensor_regs_pkg::config_s config_out,
    output logic [4:0] upper_range_index_out,
    output logic [4:0] lower_range_index_out,
    output logic prox_read_out
);
    import sensor_regs_pkg::*;

    // ----------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // sclk must stay below about a quarter of ref_clk, edges are oversampled
    logic [2:0] pins_s;
    pin_sync #(.WIDTH(3), .RESET_VAL(3'h2)) u_pin_sync (
        .clk_in(ref_clk_in),
        .reset_n_in(rst_n),
        .async_in({sclk_in, chip_select_n_in, mosi_in}),
        .sync_out(pins_s)
    );
    logic sclk_s;
    logic chip_select_n_s;
    logic mosi_s;
    logic sclk_d;
    assign sclk_s = pins_s[2];
    assign chip_select_n_s = pins_s[1];
    assign mosi_s = pins_s[0];
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end
    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;

    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    phase_e phase, next_phase;
    logic [2:0] bitcnt, next_bitcnt;
    logic [7:0] rx, next_rx;
    logic [7:0] tx, next_tx;
    logic [6:0] addr, next_addr;
    logic dir, next_dir;
    logic miso, next_miso;
    logic wr_fire;
    logic tx_load;
    logic [6:0] look_addr;
    logic [7:0] rd_data;
    config_s cfg, next_cfg;
    logic [7:0] rsvd06, next_rsvd06;
    logic [7:0] rsvd08, next_rsvd08;

    // address whose byte goes out next: new command address or the next one
    assign look_addr = (phase == PH_CMD) ? {rx[5:0], mosi_s} : addr + 7'h01;

    always_comb begin
        unique case (look_addr)
            ADDR_REVISION: rd_data = REVISION_ID;
            ADDR_UPPER: rd_data = cfg.resist_range_upper;
            ADDR_LOWER: rd_data = cfg.resist_range_lower;
            ADDR_WATCHDOG: rd_data = cfg.min_sensor_freq_watchdog;
            ADDR_CONV_CFG: rd_data = cfg.converter_config;
            ADDR_RSVD_05: rd_data = VAL_RSVD_05;
            ADDR_RSVD_06: rd_data = rsvd06;
            ADDR_THR_HIGH: rd_data = cfg.prox_threshold_high;
            ADDR_RSVD_08: rd_data = rsvd08;
            ADDR_THR_LOW: rd_data = cfg.prox_threshold_low;
            ADDR_INT_CFG: rd_data = cfg.interrupt_pin_config;
            ADDR_POWER: rd_data = {7'h00, cfg.active_mode_bit};
            ADDR_STATUS: rd_data = {result_in.osc_dead, result_in.data_ready_n,
                                    result_in.wakeup_n, result_in.comparator, 4'h0};
            ADDR_PROX: rd_data = result_in.proximity;
            ADDR_FREQ_LOW: rd_data = result_in.freq_count[7:0];
            ADDR_FREQ_MID: rd_data = result_in.freq_count[15:8];
            ADDR_FREQ_HIGH: rd_data = result_in.freq_count[23:16];
            default: rd_data = 8'h00;
        endcase
    end

    always_comb begin
        next_phase = phase;
        next_bitcnt = bitcnt;
        next_rx = rx;
        next_tx = tx;
        next_addr = addr;
        next_dir = dir;
        next_miso = miso;
        wr_fire = 1'b0;
        tx_load = 1'b0;
        if (chip_select_n_s) begin
            next_phase = PH_CMD;
            next_bitcnt = 3'h0;
        end else if (sclk_rise) begin
            next_rx = {rx[6:0], mosi_s};
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == BIT_LAST) begin
                unique case (phase)
                    PH_CMD: begin
                        next_dir = next_rx[DIR_BIT];
                        next_addr = next_rx[6:0];
                        next_phase = PH_DATA;
                        tx_load = (next_rx[DIR_BIT] == DIR_READ);
                    end
                    PH_DATA: begin
                        wr_fire = (dir != DIR_READ);
                        next_addr = addr + 7'h01;
                        tx_load = (dir == DIR_READ);
                    end
                endcase
            end
        end else if (sclk_fall) begin
            next_miso = tx[7];
            next_tx = {tx[6:0], 1'b0};
        end
        if (tx_load) begin
            next_tx = rd_data;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_CMD;
            bitcnt <= 3'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            addr <= 7'h00;
            dir <= 1'b0;
            miso <= 1'b0;
            prox_read_out <= 1'b0;
        end else begin
            phase <= next_phase;
            bitcnt <= next_bitcnt;
            rx <= next_rx;
            tx <= next_tx;
            addr <= next_addr;
            dir <= next_dir;
            miso <= next_miso;
            prox_read_out <= tx_load && (look_addr == ADDR_PROX);
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic locked;
    assign locked = cfg.active_mode_bit && (addr >= ADDR_LOCK_FIRST) && (addr <= ADDR_LOCK_LAST);

    always_comb begin
        next_cfg = cfg;
        next_rsvd06 = rsvd06;
        next_rsvd08 = rsvd08;
        // commit on the data byte's last rise
        if (wr_fire && !locked) begin
            unique case (addr)
                ADDR_UPPER: next_cfg.resist_range_upper = next_rx;
                ADDR_LOWER: next_cfg.resist_range_lower = next_rx;
                ADDR_WATCHDOG: next_cfg.min_sensor_freq_watchdog = next_rx;
                ADDR_CONV_CFG: next_cfg.converter_config = next_rx;
                ADDR_RSVD_06: next_rsvd06 = next_rx;
                ADDR_THR_HIGH: next_cfg.prox_threshold_high = next_rx;
                ADDR_RSVD_08: next_rsvd08 = next_rx;
                ADDR_THR_LOW: next_cfg.prox_threshold_low = next_rx;
                ADDR_INT_CFG: next_cfg.interrupt_pin_config = next_rx;
                ADDR_POWER: next_cfg.active_mode_bit = next_rx[ACTIVE_BIT];
                default: next_cfg = cfg;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= '{RST_UPPER, RST_LOWER, RST_WATCHDOG, RST_CONV_CFG,
                     RST_THR_HIGH, RST_THR_LOW, RST_INT_CFG, RST_ACTIVE};
            rsvd06 <= RST_RSVD_06;
            rsvd08 <= RST_RSVD_08;
        end else begin
            cfg <= next_cfg;
            rsvd06 <= next_rsvd06;
            rsvd08 <= next_rsvd08;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign config_out = cfg;
    assign miso_out = miso;
    assign miso_oe_out = ~chip_select_n_s;
    assign upper_range_index_out = range_index(cfg.resist_range_upper);
    assign lower_range_index_out = range_index(cfg.resist_range_lower);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);

    chk_lock_holds: assert property (
        wr_fire && cfg.active_mode_bit && addr == ADDR_UPPER |=> $stable(cfg.resist_range_upper))
        else $error("locked upper limit changed");
    chk_upper_write: assert property (
        wr_fire && !cfg.active_mode_bit && addr == ADDR_UPPER
        |=> cfg.resist_range_upper == rx && upper_range_index_out == rx[RANGE_MSB:0])
        else $error("upper limit write lost");
    chk_lower_write: assert property (
        wr_fire && !cfg.active_mode_bit && addr == ADDR_LOWER
        |=> cfg.resist_range_lower == rx && lower_range_index_out == rx[RANGE_MSB:0]
        ##1 $stable(cfg.resist_range_lower))
        else $error("lower limit write lost");
    chk_revision_read: assert property (
        tx_load && look_addr == ADDR_REVISION |=> tx == REVISION_ID)
        else $error("revision read wrong");
    chk_undef_zero: assert property (
        tx_load && look_addr > ADDR_POWER && look_addr < ADDR_STATUS |=> tx == 8'h00)
        else $error("undefined read not zero");
    chk_cmd_decode: assert property (
        sclk_rise && !chip_select_n_s && phase == PH_CMD && bitcnt == BIT_LAST
        |=> phase == PH_DATA && {dir, addr} == rx)
        else $error("command byte misdecoded");
    chk_addr_incr: assert property (
        sclk_rise && !chip_select_n_s && phase == PH_DATA && bitcnt == BIT_LAST
        |=> addr == $past(addr) + 7'h01)
        else $error("address did not increment");
    chk_no_early_write: assert property (
        chip_select_n_s || phase == PH_CMD || bitcnt != BIT_LAST |-> !wr_fire)
        else $error("write outside 16th edge");
    chk_power_bit: assert property (
        wr_fire && addr == ADDR_POWER |=> config_out.active_mode_bit == rx[ACTIVE_BIT])
        else $error("power bit not taken");

    cov_write_commit: cover property (wr_fire && !locked);
    cov_locked_write: cover property (wr_fire && locked);
    cov_prox_read: cover property (prox_read_out);
    cov_burst_read: cover property (tx_load && phase == PH_DATA);

endmodule // inductive_sensor_register_bank
`default_nettype wire

// ### verif/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    // clock
    input wire logic clk_in,
    // serial port pins
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic miso_oe_in
);
    logic [7:0] wr_data [16];
    logic [7:0] rd_data [16];

    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // half period of 80 ns keeps well above the 40 ns minimum
    task automatic half();
        repeat (8) @(posedge clk_in);
        #1;
    endtask

    // ----------------------------------------
    // frame: command byte then data bytes
    // ----------------------------------------
    // direction bit and address
    // data bytes come from the bench, defaults in reserved fields
    task automatic frame(input logic [7:0] cmd, input int nbits);
        logic [7:0] sh;
        sh = cmd;
        cs_n_out = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            if (i > 0 && i % 8 == 0) begin
                sh = wr_data[i / 8 - 1];
            end
            mosi_out = sh[7];
            half();
            // an undriven pin reads inverted, so a stale bit cannot pass
            if (i >= 8) begin
                rd_data[i / 8 - 1] = {rd_data[i / 8 - 1][6:0], miso_oe_in ? miso_in : ~miso_in};
            end
            sclk_out = 1'b1;
            half();
            sclk_out = 1'b0;
            sh = sh << 1;
        end
        half();
        cs_n_out = 1'b1;
        // released line must not keep the last bit
        mosi_out = ~mosi_out;
        repeat (6) @(posedge clk_in);
        #1;
    endtask
endmodule // spi_host_model
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sensor_regs_pkg::*;
    // value is arbitrary
    localparam logic [7:0] REV = 8'h3C;
    logic ref_clk, reset_n, sclk, cs_n, mosi, miso, miso_oe, prox_read;
    result_s result;
    config_s cfg;
    logic [4:0] up_idx, lo_idx;
    int errors = 0;
    int n_compared = 0;
    int prox_cnt = 0;

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    inductive_sensor_register_bank #(.REVISION_ID(REV)) inductive_sensor_register_bank_inst (
        .ref_clk_in(ref_clk), .reset_n_in(reset_n), .sclk_in(sclk), .chip_select_n_in(cs_n),
        .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .result_in(result),
        .config_out(cfg), .upper_range_index_out(up_idx), .lower_range_index_out(lo_idx),
        .prox_read_out(prox_read));

    spi_host_model spi_host_model_inst (.clk_in(ref_clk), .sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi), .miso_in(miso), .miso_oe_in(miso_oe));

    always @(negedge ref_clk) begin
        if (prox_read === 1'b1) prox_cnt++;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic put(input logic [7:0] cmd, input logic [7:0] d, input int n);
        spi_host_model_inst.wr_data[0] = d;
        spi_host_model_inst.frame(cmd, n);
    endtask

    task automatic finish_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        logic [7:0] exp [12] = '{REV, 8'h0E, 8'h14, 8'h45, 8'h1B, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
        check({7'h00, miso_oe}, 8'h00);
        check(cfg.resist_range_upper, 8'h0E);
        check(cfg.resist_range_lower, 8'h14);
        check({3'h0, up_idx}, 8'h0E);
        check({3'h0, lo_idx}, 8'h14);
        spi_host_model_inst.frame(8'h80, 104);
        for (int i = 0; i < 12; i++) begin
            check(spi_host_model_inst.rd_data[i], exp[i]);
        end
        $display("test_reset done");
    endtask

    task automatic test_limits();
        spi_host_model_inst.wr_data[1] = 8'h3F;
        put(8'h01, 8'h1F, 24);
        check(cfg.resist_range_upper, 8'h1F);
        check(cfg.resist_range_lower, 8'h3F);
        check({3'h0, up_idx}, 8'h1F);
        check({3'h0, lo_idx}, 8'h1F);
        put(8'h00, 8'h11, 16);
        put(8'h05, 8'h01, 16);
        put(8'h0C, 8'h11, 16);
        spi_host_model_inst.frame(8'h80, 16);
        check(spi_host_model_inst.rd_data[0], REV);
        spi_host_model_inst.frame(8'h85, 16);
        check(spi_host_model_inst.rd_data[0], 8'h01);
        spi_host_model_inst.frame(8'h8C, 16);
        check(spi_host_model_inst.rd_data[0], 8'h00);
        $display("test_limits done");
    endtask

    task automatic test_abort();
        put(8'h07, 8'h33, 15);
        check(cfg.prox_threshold_high, 8'hFF);
        put(8'h07, 8'h33, 16);
        check(cfg.prox_threshold_high, 8'h33);
        $display("test_abort done");
    endtask

    task automatic test_lock();
        put(8'h0B, 8'h01, 16);
        check({7'h00, cfg.active_mode_bit}, 8'h01);
        put(8'h01, 8'h05, 16);
        check(cfg.resist_range_upper, 8'h1F);
        put(8'h04, 8'h05, 16);
        check(cfg.converter_config, 8'h1B);
        put(8'h09, 8'h05, 16);
        check(cfg.prox_threshold_low, 8'h05);
        put(8'h0B, 8'h00, 16);
        check({7'h00, cfg.active_mode_bit}, 8'h00);
        put(8'h01, 8'h05, 16);
        check(cfg.resist_range_upper, 8'h05);
        $display("test_lock done");
    endtask

    task automatic test_results();
        logic [7:0] exp [6] = '{8'hA0, 8'h00, 8'hA7, 8'h56, 8'h34, 8'h12};
        result = '{osc_dead: 1'b1, data_ready_n: 1'b0, wakeup_n: 1'b1, comparator: 1'b0,
                   proximity: 8'hA7, freq_count: 24'h123456};
        prox_cnt = 0;
        spi_host_model_inst.frame(8'hA0, 56);
        for (int i = 0; i < 6; i++) begin
            check(spi_host_model_inst.rd_data[i], exp[i]);
        end
        check(prox_cnt[7:0], 8'h01);
        $display("test_results done");
    endtask

    // every frame is a fixed number of cycles, so a hang is cut here
    initial begin
        #200000;
        errors++;
        finish_test();
    end

    initial begin
        reset_n = 1'b0;
        result = '0;
        repeat (8) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        test_reset();
        test_limits();
        test_abort();
        test_lock();
        test_results();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
